/* File: rtl/eid_pkg.sv */
// Package: register map, field layout and shared types for the edge detector
package eid_pkg;
   // Register offsets on the plain register port
   localparam logic [11:0] ADDR_CTL2 = 12'hFD9;
   localparam logic [11:0] ADDR_CTL3 = 12'hFDA;
   localparam logic [11:0] ADDR_PWR  = 12'hFE0;
   localparam logic [11:0] ADDR_STAT = 12'hFE1;
   localparam logic [11:0] ADDR_MASK = 12'hFE2;

   // Field positions in a control register
   localparam int LVL_BIT = 4;
   localparam int ES_LSB  = 2;
   localparam int NC_LSB  = 0;

   // Edge-select codes
   localparam logic [1:0] ES_RISE = 2'h0;
   localparam logic [1:0] ES_FALL = 2'h1;
   localparam logic [1:0] ES_BOTH = 2'h2;
   localparam logic [1:0] ES_RSVD = 2'h3;

   // Sampling-interval codes: gear clock divided by 1, 4, 8, 16
   localparam logic [1:0] NC_DIV1  = 2'h0;
   localparam logic [1:0] NC_DIV4  = 2'h1;
   localparam logic [1:0] NC_DIV8  = 2'h2;
   localparam logic [1:0] NC_DIV16 = 2'h3;

   // Low-frequency clock edges per slow-mode sample, minus one
   localparam logic [1:0] LF_DIV_LAST = 2'h3;

   // Values after reset
   localparam logic [3:0] CTL_RESET  = 4'h0;
   localparam logic [1:0] PWR_RESET  = 2'h0;
   localparam logic [1:0] MASK_RESET = 2'h0;
   localparam logic [1:0] STAT_RESET = 2'h0;

   // Writable control fields of one input
   typedef struct packed {
      logic [1:0] edge_sel;
      logic [1:0] interval;
   } eid_ctl_t;

   // Everything one input channel reports to the top
   typedef struct packed {
      logic     req;
      logic     level;
      eid_ctl_t ctl;
   } eid_chan_t;

   // Sample strobe in normal modes from the shared prescaler count
   function automatic logic tick_sel(input logic [1:0] nc, input logic [3:0] pre);
      case (nc)
         NC_DIV1:  tick_sel = 1'b1;
         NC_DIV4:  tick_sel = (pre[1:0] == 2'h0);
         NC_DIV8:  tick_sel = (pre[2:0] == 3'h0);
         default:  tick_sel = (pre == 4'h0);
      endcase
   endfunction

   // Read image of a control register, upper bits zero
   function automatic logic [7:0] ctl_image(input eid_chan_t ch);
      ctl_image = {3'h0, ch.level, ch.ctl.edge_sel, ch.ctl.interval};
   endfunction
endpackage

/* File: rtl/eid_channel.sv */
// One external input: control register, noise canceller and edge detector
`timescale 1ns/1ps
module eid_channel (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              enable,
   input  wire logic              slow,
   input  wire logic              slow_tick,
   input  wire logic [3:0]        pre,
   input  wire logic              pin,
   input  wire logic              wr_ctl,
   input  wire logic [3:0]        wdata,
   output eid_pkg::eid_chan_t     chan
);
   eid_pkg::eid_ctl_t ctl;
   logic [2:0]        hist;
   logic              filt;
   logic              filt_d;
   logic              req;
   logic              level;
   logic              tick;
   logic              hit;

   // Sample strobe: fixed low-frequency rate in slow modes
   assign tick = slow ? slow_tick                                  // RULE3
                      : eid_pkg::tick_sel(ctl.interval, pre);      // RULE2

   // Control register, lost while the channel is powered off
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl <= eid_pkg::CTL_RESET;
      end else if (!enable) begin
         ctl <= eid_pkg::CTL_RESET;                                // RULE10
      end else if (wr_ctl) begin
         ctl <= wdata;                                             // RULE13
      end
   end

   // Noise canceller: three equal samples move the pass signal
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hist <= 3'h0;
         filt <= 1'b0;
      end else if (!enable) begin
         hist <= 3'h0;
         filt <= 1'b0;
      end else if (tick) begin
         hist <= {hist[1:0], pin};
         if ({hist[1:0], pin} == 3'h7) begin
            filt <= 1'b1;                                          // RULE12
         end else if ({hist[1:0], pin} == 3'h0) begin
            filt <= 1'b0;                                          // RULE12
         end
      end
   end

   // Previous pass level for edge detection
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         filt_d <= 1'b0;
      end else begin
         filt_d <= enable & filt;
      end
   end

   // Edge match by selected condition
   always_comb begin
      case (ctl.edge_sel)
         eid_pkg::ES_RISE: hit = filt & ~filt_d;                   // RULE1
         eid_pkg::ES_FALL: hit = ~filt & filt_d;                   // RULE1
         eid_pkg::ES_BOTH: hit = filt ^ filt_d;                    // RULE1
         default:          hit = 1'b0;
      endcase
   end

   // Request pulse and captured pass level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         req   <= 1'b0;
         level <= 1'b0;
      end else begin
         req <= enable & hit;
         if (!enable) begin
            level <= 1'b0;
         end else if (hit) begin
            level <= filt;                                         // RULE4 RULE11
         end
      end
   end

   assign chan = '{req: req, level: level, ctl: ctl};

   a_rise_req: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
      enable && ctl.edge_sel == eid_pkg::ES_RISE && filt && !filt_d |=> req)
      else $error("rising edge gave no request");
   a_rsvd_quiet: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
      ctl.edge_sel == eid_pkg::ES_RSVD |=> !req)
      else $error("reserved edge code gave a request");
   a_level_capture: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
      req |-> level == filt_d)
      else $error("captured level differs from pass level");
   a_div4_rate: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
      !slow && ctl.interval == eid_pkg::NC_DIV4 && tick |-> pre[1:0] == 2'h0)
      else $error("divide-by-four sample off its slot");
   a_filter_tick: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
      enable && $past(enable) && !$stable(filt) |-> $past(tick) && $past(pin) == filt)
      else $error("pass signal moved without a sample");
   a_power_off: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
      !enable |=> ctl == eid_pkg::CTL_RESET && !req)
      else $error("powered-off channel kept state");
   a_ctl_write: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
      enable && wr_ctl |=> ctl == $past(wdata))
      else $error("control write not stored");
endmodule

/* File: rtl/eid_top.sv */
// Top: register port, clock prescaling and two external input channels
//
// Summary of operation
// RULE1: Edge code picks rising, falling, both; 11 none
// RULE2: Normal modes sample at gear clock /1,/4,/8,/16
// RULE3: Slow modes sample at low clock over four
// RULE4: Bit 4 holds pass level at last request
// RULE5: Control bits 7 to 5 read zero
// RULE6: Software disables interrupt before changing clock mode
// RULE7: Software clears latch twelve slow clocks after
// RULE8: Software clears latch after returning to normal
// RULE9: Software disables interrupt before editing control registers
// RULE10: Power enable off clears channel and its control
// RULE11: Captured level refreshes on each new request
// RULE12: Short pulses rejected, long pulses accepted as signal
// RULE13: Edge field bits 3:2, interval bits 1:0
// RULE14: Two independent identical channels
`timescale 1ns/1ps
module eid_top (
   input  wire logic        CLK,
   input  wire logic        NRST,
   input  wire logic [11:0] ADDR,
   input  wire logic [7:0]  WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [7:0]  RDATA,
   input  wire logic [1:0]  EXT_IN,
   input  wire logic        LF_CLK,
   input  wire logic        SLOW_MODE,
   output logic      [1:0]  IRQ_REQ,
   output logic             IRQ
);
   logic [1:0]         rst_sync;
   logic               rst_n;
   logic [3:0]         pin_meta;
   logic [3:0]         pin_sync;
   logic               lf_last;
   logic               lf_rise;
   logic [1:0]         lf_cnt;
   logic               slow_tick;
   logic [3:0]         pre;
   logic [1:0]         pwr;
   logic [1:0]         mask;
   logic [1:0]         status;
   logic [1:0]         req;
   logic [1:0]         wr_ctl;
   logic               rd_stat;
   logic [7:0]         next_rdata;
   eid_pkg::eid_chan_t chan [2];

   // Reset release through two flops
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // Two-flop synchronisers for pins, low clock and mode
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta <= 4'h0;
         pin_sync <= 4'h0;
      end else begin
         pin_meta <= {SLOW_MODE, LF_CLK, EXT_IN};
         pin_sync <= pin_meta;
      end
   end

   // Rising edge of the synchronised low-frequency clock
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         lf_last <= 1'b0;
      end else begin
         lf_last <= pin_sync[2];
      end
   end
   assign lf_rise = pin_sync[2] & ~lf_last;

   // Slow-mode sample strobe on every fourth low clock edge
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         lf_cnt    <= 2'h0;
         slow_tick <= 1'b0;
      end else begin
         slow_tick <= lf_rise && lf_cnt == eid_pkg::LF_DIV_LAST;   // RULE3
         if (lf_rise) begin
            lf_cnt <= lf_cnt + 2'h1;
         end
      end
   end

   // Free-running gear clock prescaler shared by both channels
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         pre <= 4'h0;
      end else begin
         pre <= pre + 4'h1;
      end
   end

   // Write decode for the control registers, read decode for status
   assign wr_ctl[0] = WR && ADDR == eid_pkg::ADDR_CTL2;
   assign wr_ctl[1] = WR && ADDR == eid_pkg::ADDR_CTL3;
   assign rd_stat   = RD && ADDR == eid_pkg::ADDR_STAT;

   // Two independent channels, one per input
   for (genvar i = 0; i < 2; i++) begin : g_chan
      eid_channel u_chan (                                          // RULE14
         .clk       (CLK),
         .rst_n     (rst_n),
         .enable    (pwr[i]),
         .slow      (pin_sync[3]),
         .slow_tick (slow_tick),
         .pre       (pre),
         .pin       (pin_sync[i]),
         .wr_ctl    (wr_ctl[i]),
         .wdata     (WDATA[3:0]),
         .chan      (chan[i])
      );
      assign req[i] = chan[i].req;
   end

   // Power enable and mask registers
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         pwr  <= eid_pkg::PWR_RESET;
         mask <= eid_pkg::MASK_RESET;
      end else if (WR) begin
         if (ADDR == eid_pkg::ADDR_PWR) begin
            pwr <= WDATA[1:0];                                     // RULE10
         end
         if (ADDR == eid_pkg::ADDR_MASK) begin
            mask <= WDATA[1:0];
         end
      end
   end

   // Sticky status, cleared by a read; a new request wins
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         status <= eid_pkg::STAT_RESET;
      end else begin
         status <= (rd_stat ? 2'h0 : status) | req;
      end
   end

   // Read data multiplexer
   always_comb begin
      next_rdata = 8'h00;
      if (RD) begin
         case (ADDR)
            eid_pkg::ADDR_CTL2: next_rdata = eid_pkg::ctl_image(chan[0]); // RULE5
            eid_pkg::ADDR_CTL3: next_rdata = eid_pkg::ctl_image(chan[1]); // RULE5
            eid_pkg::ADDR_PWR:  next_rdata = {6'h00, pwr};
            eid_pkg::ADDR_STAT: next_rdata = {6'h00, status};
            eid_pkg::ADDR_MASK: next_rdata = {6'h00, mask};
            default:            next_rdata = 8'h00;
         endcase
      end
   end

   // Registered outputs
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         RDATA <= 8'h00;
         IRQ   <= 1'b0;
      end else begin
         RDATA <= next_rdata;
         IRQ   <= |(((rd_stat ? 2'h0 : status) | req) & mask);
      end
   end
   assign IRQ_REQ = req;

   a_ctl_upper: assert property (@(posedge CLK) disable iff (!rst_n) // RULE5
      $past(RD) && ($past(ADDR) == eid_pkg::ADDR_CTL2
                    || $past(ADDR) == eid_pkg::ADDR_CTL3) |-> RDATA[7:5] == 3'h0)
      else $error("control upper bits not zero");
   a_slow_rate: assert property (@(posedge CLK) disable iff (!rst_n) // RULE3
      lf_rise && lf_cnt == eid_pkg::LF_DIV_LAST |=> slow_tick ##1 !slow_tick)
      else $error("slow sample strobe missing");
   a_status_sticky: assert property (@(posedge CLK) disable iff (!rst_n) // RULE14
      req[0] |=> status[0] [*2] or (status[0] ##1 $past(rd_stat)))
      else $error("request lost from status");
   a_irq_level: assert property (@(posedge CLK) disable iff (!rst_n)
      |(status & mask) && !rd_stat |=> IRQ)
      else $error("unmasked status without interrupt");

   // Read data back to zero outside the read slot
   a_rdata_idle: assert property (@(posedge CLK) disable iff (!rst_n)
      !$past(RD) |-> RDATA == 8'h00)
      else $error("read data outside the read slot");

   // Level bit reads back as captured
   a_level_read: assert property (@(posedge CLK) disable iff (!rst_n) // RULE4
      $past(RD) && $past(ADDR) == eid_pkg::ADDR_CTL2
      |-> RDATA[eid_pkg::LVL_BIT] == $past(chan[0].level))
      else $error("level bit read differs from capture");

   // Power enable write lands
   a_pwr_write: assert property (@(posedge CLK) disable iff (!rst_n) // RULE10
      WR && ADDR == eid_pkg::ADDR_PWR |=> pwr == $past(WDATA[1:0]))
      else $error("power enable write not stored");

   // Status read clears when no request races it
   a_stat_clear: assert property (@(posedge CLK) disable iff (!rst_n)
      rd_stat && req == 2'h0 |=> status == 2'h0)
      else $error("status not cleared by read");

   // Second input request lands in status
   a_status_three: assert property (@(posedge CLK) disable iff (!rst_n) // RULE14
      req[1] |=> status[1])
      else $error("second input request lost from status");

   // Filtered requests never come back to back
   a_req_single: assert property (@(posedge CLK) disable iff (!rst_n) // RULE12
      req[0] |=> !req[0])
      else $error("back-to-back request from one input");

   // Interrupt only from an unmasked status bit
   a_irq_source: assert property (@(posedge CLK) disable iff (!rst_n)
      IRQ |-> |(status & $past(mask)))
      else $error("interrupt without unmasked status");

   // Fully masked status keeps the interrupt low
   a_mask_quiet: assert property (@(posedge CLK) disable iff (!rst_n)
      mask == 2'h0 |=> !IRQ)
      else $error("interrupt raised while fully masked");
endmodule

/* File: tb/eid_pins.sv */
// Board-side model of the two external pins and the slow clock
`timescale 1ns/1ps
module eid_pins (
   input  wire logic [1:0] lvl,
   input  wire logic       lf_run,
   output logic      [1:0] ext_in,
   output logic            lf_clk
);
   // Pins follow the board level; no pull, driven always
   assign ext_in = lvl;
   // Slow clock, phase unrelated to the gear clock
   initial lf_clk = 1'b0;
   always begin
      #37.3;
      lf_clk = lf_run ? ~lf_clk : 1'b0;
   end
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the two-input edge detector
`timescale 1ns/1ps
module tb;
   logic        CLK, NRST, WR, RD, LF_CLK, SLOW_MODE, IRQ, lf_run;
   logic [11:0] ADDR;
   logic [7:0]  WDATA, RDATA, d;
   logic [1:0]  lvl, EXT_IN, IRQ_REQ;
   int          bad_count, n_checks, n0, n1;

   eid_top uut (.CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .EXT_IN(EXT_IN), .LF_CLK(LF_CLK), .SLOW_MODE(SLOW_MODE),
      .IRQ_REQ(IRQ_REQ), .IRQ(IRQ));
   eid_pins pins (.lvl(lvl), .lf_run(lf_run), .ext_in(EXT_IN), .lf_clk(LF_CLK));

   // Gear clock, 4 ns period
   always #2 CLK = ~CLK;
   // Request pulse counters per input
   always @(posedge CLK) begin
      if (IRQ_REQ[0] === 1'b1) n0 <= n0 + 1;
      if (IRQ_REQ[1] === 1'b1) n1 <= n1 + 1;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge CLK);
      ADDR  <= a;
      WDATA <= v;
      WR    <= 1'b1;
      @(posedge CLK);
      WR    <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [7:0] v);
      @(posedge CLK);
      ADDR <= a;
      RD   <= 1'b1;
      @(posedge CLK);
      RD   <= 1'b0;
      #1 v = RDATA;
   endtask
   // Hold the pins at a level for some cycles
   task automatic hold(input logic [1:0] l, input int c);
      @(posedge CLK);
      lvl <= l;
      repeat (c) @(posedge CLK);
   endtask
   function automatic int cn(input int ch);
      return ch ? n1 : n0;
   endfunction

   // Reset values, unmapped place, power gating of control
   task automatic t_regs();
      logic [11:0] ra[6] = '{12'hFD9, 12'hFDA, 12'hFE0, 12'hFE1, 12'hFE2, 12'h123};
      foreach (ra[i]) begin
         rd(ra[i], d);
         chk(d, 8'h00);
      end
      wr(eid_pkg::ADDR_CTL2, 8'h0E);
      rd(eid_pkg::ADDR_CTL2, d);
      chk(d, 8'h00);
      wr(eid_pkg::ADDR_PWR, 8'h03);
      wr(eid_pkg::ADDR_CTL2, 8'hFF);
      rd(eid_pkg::ADDR_CTL2, d);
      chk(d, 8'h0F);
      wr(eid_pkg::ADDR_CTL3, 8'hE6);
      rd(eid_pkg::ADDR_CTL3, d);
      chk(d, 8'h06);
      wr(eid_pkg::ADDR_PWR, 8'h00);
      wr(eid_pkg::ADDR_PWR, 8'h03);
      rd(eid_pkg::ADDR_CTL2, d);
      chk(d, 8'h00);
   endtask

   // Every edge code on both inputs, with the captured level
   task automatic t_edges();
      int m, o;
      logic [11:0] a;
      wr(eid_pkg::ADDR_MASK, 8'h00);
      for (int ch = 0; ch < 2; ch++) begin
         a = ch ? eid_pkg::ADDR_CTL3 : eid_pkg::ADDR_CTL2;
         for (int es = 0; es < 4; es++) begin
            wr(a, {4'h0, es[1:0], 2'h0});
            m = cn(ch);
            o = n0 + n1;
            hold(ch ? 2'h2 : 2'h1, 20);
            chk(8'(cn(ch) - m), 8'(es == 0 || es == 2));
            chk(8'(n0 + n1 - o), 8'(es == 0 || es == 2));
            rd(a, d);
            chk(d, {3'h0, es != 3, es[1:0], 2'h0});
            m = cn(ch);
            hold(2'h0, 20);
            chk(8'(cn(ch) - m), 8'(es == 1 || es == 2));
            rd(a, d);
            chk(d, {3'h0, es == 0, es[1:0], 2'h0});
         end
      end
   endtask

   // Each interval code: pulse under three samples lost, long pulse kept
   task automatic t_filter();
      int p, m;
      for (int k = 0; k < 4; k++) begin
         p = (k == 0) ? 1 : (2 << k);
         wr(eid_pkg::ADDR_CTL2, 8'(k));
         m = n0;
         hold(2'h1, p);
         hold(2'h0, 4 * p + 8);
         chk(8'(n0 - m), 8'h00);
         hold(2'h1, 4 * p + 3);
         hold(2'h0, 4 * p + 8);
         chk(8'(n0 - m), 8'h01);
      end
   endtask

   // Slow mode ignores the interval code
   task automatic t_slow();
      int m;
      wr(eid_pkg::ADDR_CTL2, 8'h00);
      @(posedge CLK);
      SLOW_MODE <= 1'b1;
      repeat (230) @(posedge CLK);
      rd(eid_pkg::ADDR_STAT, d);
      m = n0;
      hold(2'h1, 100);
      hold(2'h0, 400);
      chk(8'(n0 - m), 8'h00);
      hold(2'h1, 400);
      hold(2'h0, 400);
      chk(8'(n0 - m), 8'h01);
      SLOW_MODE <= 1'b0;
      repeat (10) @(posedge CLK);
      rd(eid_pkg::ADDR_STAT, d);
   endtask

   // Status, mask and the level interrupt
   task automatic t_irq();
      wr(eid_pkg::ADDR_CTL3, 8'h00);
      wr(eid_pkg::ADDR_MASK, 8'h01);
      hold(2'h1, 20);
      chk({7'h0, IRQ}, 8'h01);
      rd(eid_pkg::ADDR_STAT, d);
      chk(d, 8'h01);
      @(posedge CLK);
      #1 chk({7'h0, IRQ}, 8'h00);
      hold(2'h3, 20);
      chk({7'h0, IRQ}, 8'h00);
      rd(eid_pkg::ADDR_STAT, d);
      chk(d, 8'h02);
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Watchdog against a hang
   initial begin
      #100000;
      bad_count++;
      results();
   end

   // Main sequence
   initial begin
      {CLK, NRST, WR, RD, SLOW_MODE, lvl, ADDR, WDATA} = '0;
      {bad_count, n_checks, n0, n1} = '0;
      lf_run = 1'b1;
      repeat (4) @(posedge CLK);
      NRST <= 1'b1;
      repeat (4) @(posedge CLK);
      t_regs();
      t_edges();
      t_filter();
      t_slow();
      t_irq();
      results();
   end
endmodule
